//--- pfm_pkg.sv
// shared constants for the port pin function multiplexer
package pfm_pkg;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int PORT_W = 8;
	localparam logic [7:0] P0_LAT_RST = 8'hFF; // open-drain off, pins float
	localparam logic [7:0] QB_LAT_RST = 8'hFF; // weak pullups hold high
	localparam logic [7:0] ALL_OFF = 8'h00;

	// ------------------------------------------------------------
	// timing of the strong high driver after a 0 to 1 change
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int STRONG_PULSE_NS = 100;
	localparam int STRONG_PULSE_CYC_I = (STRONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CW = 2;
	localparam logic [PULSE_CW-1:0] STRONG_PULSE_CYC = PULSE_CW'(STRONG_PULSE_CYC_I);

	// ------------------------------------------------------------
	// third port pin positions
	// ------------------------------------------------------------
	localparam int P3_SER0_RX_BIT = 0;
	localparam int P3_SER0_TX_BIT = 1;
	localparam int P3_IRQ0_BIT = 2;
	localparam int P3_IRQ1_BIT = 3;
	localparam int P3_TMR0_BIT = 4;
	localparam int P3_WR_STB_BIT = 6;
	localparam int P3_RD_STB_BIT = 7;

	// ------------------------------------------------------------
	// fourth port field positions
	// ------------------------------------------------------------
	localparam int P4_SR_LSB = 0;
	localparam int P4_SR_W = 6;
	localparam int P4_TG_LSB = 6;
	localparam int P4_TG_W = 2;

endpackage

//--- pfm_qb_if.sv
// carrier between the port multiplexer and its quasi-bidirectional drivers
`timescale 1ns/1ns
interface pfm_qb_if #(
	parameter int W = 8
);
	logic [W-1:0] out_val;      // level wanted on each pin
	logic [W-1:0] force_strong; // drive both levels hard
	logic [W-1:0] pin_o;
	logic [W-1:0] pin_oe;
	logic [W-1:0] pin_wpu;

	modport ctl (
		output out_val,
		output force_strong,
		input pin_o,
		input pin_oe,
		input pin_wpu
	);
	modport drv (
		input out_val,
		input force_strong,
		output pin_o,
		output pin_oe,
		output pin_wpu
	);
endinterface

//--- pfm_qb_pin.sv
// quasi-bidirectional pin driver group with strong pull-up pulse
`timescale 1ns/1ns
module pfm_qb_pin #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// control and pin drive
	pfm_qb_if.drv qb
);

	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0][pfm_pkg::PULSE_CW-1:0] cnt;
		logic [W-1:0] o;
		logic [W-1:0] oe;
		logic [W-1:0] wpu;
	} pfm_qb_s;

	pfm_qb_s st_q;
	pfm_qb_s st_d;

	// ------------------------------------------------------------
	// per pin drive decision
	// ------------------------------------------------------------
	always_comb begin
		logic [pfm_pkg::PULSE_CW-1:0] n;
		n = '0;
		st_d = st_q;
		for (int i = 0; i < W; i++) begin
			st_d.prev[i] = qb.out_val[i];
			if (qb.force_strong[i]) begin
				// bus mode: push-pull both levels
				st_d.o[i] = qb.out_val[i];
				st_d.oe[i] = 1'b1;
				st_d.wpu[i] = 1'b0;
				st_d.cnt[i] = '0;
			end else if (!qb.out_val[i]) begin
				// strong pulldown held until a 1 [RQ11]
				st_d.o[i] = 1'b0;
				st_d.oe[i] = 1'b1;
				st_d.wpu[i] = 1'b0;
				st_d.cnt[i] = '0;
			end else begin
				// brief strong high, then weak pullup [RQ11]
				n = st_q.prev[i] ? st_q.cnt[i] : pfm_pkg::STRONG_PULSE_CYC;
				st_d.o[i] = 1'b1;
				st_d.oe[i] = (n != '0);
				st_d.wpu[i] = 1'b1;
				st_d.cnt[i] = (n != '0) ? n - 1'b1 : '0;
			end
		end
	end

	// ------------------------------------------------------------
	// state register, reset to weakly held high
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q.prev <= '1;
			st_q.cnt <= '0;
			st_q.o <= '0;
			st_q.oe <= '0;
			st_q.wpu <= '1; // weak high out of reset [RQ6] [RQ12]
		end else begin
			st_q <= st_d;
		end
	end

	assign qb.pin_o = st_q.o;
	assign qb.pin_oe = st_q.oe;
	assign qb.pin_wpu = st_q.wpu;

endmodule

//--- pfm_port_mux.sv
// pin logic and function selection for the four general-purpose ports
`timescale 1ns/1ns

// Behaviour
// [RQ1] low port in I/O mode only sinks
// [RQ2] low address byte shown while strobe high
// [RQ3] after strobe falls low port carries data
// [RQ4] bus mode drives ones actively high
// [RQ5] low port floats after reset
// [RQ6] high port weakly high after reset
// [RQ7] high port outputs address bits fifteen to eight
// [RQ8] third port alternate function pin map
// [RQ9] fourth port carries compare outputs
// [RQ10] third and fourth ports quasi-bidirectional I/O
// [RQ11] zero pulls strong; rising pulses strong high
// [RQ12] quasi port latches reset to ones
// [RQ13] per-pin select: latch or peripheral
// [RQ14] every pin level reaches internal logic
module pfm_port_mux #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// port latch writes from the core
	input wire logic p0_wr_en,
	input wire logic [W-1:0] p0_wr_data,
	input wire logic p2_wr_en,
	input wire logic [W-1:0] p2_wr_data,
	input wire logic p3_wr_en,
	input wire logic [W-1:0] p3_wr_data,
	input wire logic p4_wr_en,
	input wire logic [W-1:0] p4_wr_data,
	// external bus from the core
	input wire logic bus_active,
	input wire logic bus_ale,
	input wire logic [15:0] bus_addr,
	input wire logic bus_data_oe,
	input wire logic [W-1:0] bus_wr_data,
	output logic [W-1:0] bus_rd_data,
	output logic ale_out,
	// alternate function selects
	input wire logic [W-1:0] p3_alt_en,
	input wire logic [W-1:0] p4_alt_en,
	// peripheral outputs
	input wire logic serial0_transmit_out,
	input wire logic wr_strobe_b,
	input wire logic rd_strobe_b,
	input wire logic [5:0] compare_setreset_out,
	input wire logic [1:0] compare_toggle_out,
	// peripheral inputs and pin levels for the core
	output logic serial0_receive_in,
	output logic ext_irq_zero_in,
	output logic ext_irq_one_in,
	output logic timer_zero_ext_input,
	output logic [W-1:0] p0_level,
	output logic [W-1:0] p2_level,
	output logic [W-1:0] p3_level,
	output logic [W-1:0] p4_level,
	// low address and data pins
	input wire logic [W-1:0] low_addr_data_lines_i,
	output logic [W-1:0] low_addr_data_lines_o,
	output logic [W-1:0] low_addr_data_lines_oe,
	// high address pins
	input wire logic [W-1:0] high_address_lines_i,
	output logic [W-1:0] high_address_lines_o,
	output logic [W-1:0] high_address_lines_oe,
	output logic [W-1:0] high_address_lines_wpu,
	// third port pins
	input wire logic [W-1:0] p3_pin_i,
	output logic [W-1:0] p3_pin_o,
	output logic [W-1:0] p3_pin_oe,
	output logic [W-1:0] p3_pin_wpu,
	// fourth port pins
	input wire logic [W-1:0] p4_pin_i,
	output logic [W-1:0] p4_pin_o,
	output logic [W-1:0] p4_pin_oe,
	output logic [W-1:0] p4_pin_wpu
);

	typedef struct packed {
		logic [W-1:0] p0_lat;
		logic [W-1:0] p2_lat;
		logic [W-1:0] p3_lat;
		logic [W-1:0] p4_lat;
		logic [W-1:0] p0_o;
		logic [W-1:0] p0_oe;
		logic ale;
		logic [W-1:0] lv0;
		logic [W-1:0] lv2;
		logic [W-1:0] lv3;
		logic [W-1:0] lv4;
	} pfm_mux_s;

	pfm_mux_s st_q;
	pfm_mux_s st_d;

	pfm_qb_if #(.W(W)) p2_if ();
	pfm_qb_if #(.W(W)) p3_if ();
	pfm_qb_if #(.W(W)) p4_if ();

	logic [W-1:0] p3_alt_val;
	logic [W-1:0] p4_alt_val;

	// ------------------------------------------------------------
	// peripheral levels per pin; input functions leave the pin high
	// ------------------------------------------------------------
	always_comb begin
		p3_alt_val = '1;
		p3_alt_val[pfm_pkg::P3_SER0_TX_BIT] = serial0_transmit_out; // [RQ8]
		p3_alt_val[pfm_pkg::P3_WR_STB_BIT] = wr_strobe_b; // [RQ8]
		p3_alt_val[pfm_pkg::P3_RD_STB_BIT] = rd_strobe_b; // [RQ8]
		p4_alt_val = '1;
		p4_alt_val[pfm_pkg::P4_SR_LSB +: pfm_pkg::P4_SR_W] = compare_setreset_out; // [RQ9]
		p4_alt_val[pfm_pkg::P4_TG_LSB +: pfm_pkg::P4_TG_W] = compare_toggle_out; // [RQ9]
	end

	// ------------------------------------------------------------
	// latches, low port drive and pin sampling
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (p0_wr_en) begin
			st_d.p0_lat = p0_wr_data;
		end
		if (p2_wr_en) begin
			st_d.p2_lat = p2_wr_data;
		end
		if (p3_wr_en) begin
			st_d.p3_lat = p3_wr_data;
		end
		if (p4_wr_en) begin
			st_d.p4_lat = p4_wr_data;
		end
		st_d.ale = bus_ale;
		if (bus_active && bus_ale) begin
			// address phase: low byte held while strobe high [RQ2] [RQ4]
			st_d.p0_o = bus_addr[7:0];
			st_d.p0_oe = '1;
		end else if (bus_active) begin
			// data phase: drive when writing, else release [RQ3] [RQ4]
			st_d.p0_o = bus_wr_data;
			st_d.p0_oe = bus_data_oe ? '1 : pfm_pkg::ALL_OFF;
		end else begin
			// open drain: sink on 0, float on 1 [RQ1]
			st_d.p0_o = pfm_pkg::ALL_OFF;
			st_d.p0_oe = ~st_d.p0_lat;
		end
		// pin levels always handed inward [RQ14]
		st_d.lv0 = low_addr_data_lines_i;
		st_d.lv2 = high_address_lines_i;
		st_d.lv3 = p3_pin_i;
		st_d.lv4 = p4_pin_i;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q.p0_lat <= pfm_pkg::P0_LAT_RST;
			st_q.p2_lat <= pfm_pkg::QB_LAT_RST; // [RQ12]
			st_q.p3_lat <= pfm_pkg::QB_LAT_RST; // [RQ12]
			st_q.p4_lat <= pfm_pkg::QB_LAT_RST; // [RQ12]
			st_q.p0_o <= pfm_pkg::ALL_OFF;
			st_q.p0_oe <= pfm_pkg::ALL_OFF; // all pulldowns off [RQ5]
			st_q.ale <= 1'b1;
			st_q.lv0 <= '1;
			st_q.lv2 <= '1;
			st_q.lv3 <= '1;
			st_q.lv4 <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// quasi-bidirectional ports: function selection
	// ------------------------------------------------------------
	assign p2_if.out_val = bus_active ? bus_addr[15:8] : st_q.p2_lat; // [RQ7]
	assign p2_if.force_strong = bus_active ? '1 : pfm_pkg::ALL_OFF; // [RQ7]
	// per-pin select of latch or peripheral [RQ13] [RQ10]
	assign p3_if.out_val = (p3_alt_en & p3_alt_val) | (~p3_alt_en & st_q.p3_lat);
	assign p3_if.force_strong = pfm_pkg::ALL_OFF;
	assign p4_if.out_val = (p4_alt_en & p4_alt_val) | (~p4_alt_en & st_q.p4_lat);
	assign p4_if.force_strong = pfm_pkg::ALL_OFF;

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	pfm_qb_pin #(.W(W)) u_p2 (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.qb(p2_if.drv)
	);
	pfm_qb_pin #(.W(W)) u_p3 (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.qb(p3_if.drv)
	);
	pfm_qb_pin #(.W(W)) u_p4 (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.qb(p4_if.drv)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign low_addr_data_lines_o = st_q.p0_o;
	assign low_addr_data_lines_oe = st_q.p0_oe;
	assign ale_out = st_q.ale;
	assign high_address_lines_o = p2_if.pin_o;
	assign high_address_lines_oe = p2_if.pin_oe;
	assign high_address_lines_wpu = p2_if.pin_wpu;
	assign p3_pin_o = p3_if.pin_o;
	assign p3_pin_oe = p3_if.pin_oe;
	assign p3_pin_wpu = p3_if.pin_wpu;
	assign p4_pin_o = p4_if.pin_o;
	assign p4_pin_oe = p4_if.pin_oe;
	assign p4_pin_wpu = p4_if.pin_wpu;
	// sampled pin levels to peripherals and core [RQ14] [RQ8]
	assign bus_rd_data = st_q.lv0;
	assign p0_level = st_q.lv0;
	assign p2_level = st_q.lv2;
	assign p3_level = st_q.lv3;
	assign p4_level = st_q.lv4;
	assign serial0_receive_in = st_q.lv3[pfm_pkg::P3_SER0_RX_BIT];
	assign ext_irq_zero_in = st_q.lv3[pfm_pkg::P3_IRQ0_BIT];
	assign ext_irq_one_in = st_q.lv3[pfm_pkg::P3_IRQ1_BIT];
	assign timer_zero_ext_input = st_q.lv3[pfm_pkg::P3_TMR0_BIT];

endmodule

//--- pfm_board_pins.sv
// board model: device drive, outside sources and pullups per pin
`timescale 1ns/1ns
module pfm_board_pins (
	// device side
	input wire logic [7:0] o,
	input wire logic [7:0] oe,
	input wire logic [7:0] wpu,
	// outside source and resolved level
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext,
	output logic [7:0] lvl
);
	// strong drive, then source, then pullup; a bare line drifts
	assign lvl = (oe & o) | (~oe & ext_en & ext) | (~oe & ~ext_en & (wpu | ~o));
endmodule

//--- pfm_port_mux_assertions.sv
// concurrent checks on the port multiplexer ports
`timescale 1ns/1ns
module pfm_port_mux_assertions (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// external bus
	input wire logic bus_active,
	input wire logic bus_ale,
	input wire logic bus_data_oe,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wr_data,
	input wire logic ale_out,
	// pins and inputs
	input wire logic [7:0] low_addr_data_lines_o,
	input wire logic [7:0] low_addr_data_lines_oe,
	input wire logic [7:0] high_address_lines_o,
	input wire logic [7:0] high_address_lines_oe,
	input wire logic [7:0] high_address_lines_wpu,
	input wire logic [7:0] p3_pin_i,
	input wire logic ext_irq_zero_in
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_p0_io_sink: assert property (!$past(bus_active) |-> low_addr_data_lines_o == 8'h00)
		else $error("low port drives high outside bus");
	a_p0_addr_phase: assert property ($past(bus_active && bus_ale) |-> ale_out
		&& low_addr_data_lines_oe == 8'hFF && low_addr_data_lines_o == $past(bus_addr[7:0]))
		else $error("low address byte missing");
	a_p0_data_phase: assert property ($past(bus_active && !bus_ale) |-> !ale_out
		&& low_addr_data_lines_oe == {8{$past(bus_data_oe)}}
		&& (!$past(bus_data_oe) || low_addr_data_lines_o == $past(bus_wr_data)))
		else $error("data phase drive wrong");
	a_p0_reset_float: assert property (disable iff (1'b0) !rst_b |->
		low_addr_data_lines_oe == 8'h00) else $error("low port driven in reset");
	a_p2_reset_weak: assert property (disable iff (1'b0) !rst_b |->
		high_address_lines_wpu == 8'hFF && high_address_lines_oe == 8'h00)
		else $error("high port not weak high in reset");
	a_p2_addr_high: assert property ($past(bus_active) |-> high_address_lines_oe == 8'hFF
		&& high_address_lines_o == $past(bus_addr[15:8])) else $error("high address byte wrong");
	a_qb_high_pulse: assert property ($rose(high_address_lines_o[0]) && !$past(bus_active)
		&& $past(high_address_lines_oe[0])
		|-> high_address_lines_oe[0] [*2] ##1 (!high_address_lines_oe[0]
		|| !high_address_lines_o[0] || $past(bus_active))) else $error("strong pulse length wrong");
	a_irq_pin_level: assert property ($past(rst_b) |->
		ext_irq_zero_in == $past(p3_pin_i[2])) else $error("interrupt pin level lost");
endmodule

bind pfm_port_mux pfm_port_mux_assertions i_pfm_port_mux_assertions (.sys_clk, .rst_b,
	.bus_active, .bus_ale, .bus_data_oe, .bus_addr, .bus_wr_data, .ale_out,
	.low_addr_data_lines_o, .low_addr_data_lines_oe, .high_address_lines_o,
	.high_address_lines_oe, .high_address_lines_wpu, .p3_pin_i, .ext_irq_zero_in);

//--- testbench.sv
// self-checking testbench for the port multiplexer
`timescale 1ns/1ns
module testbench;
	logic sys_clk, rst_b, p0_wr_en, p2_wr_en, p3_wr_en, p4_wr_en, bus_active, bus_ale;
	logic bus_data_oe, serial0_transmit_out, wr_strobe_b, rd_strobe_b, ale_out;
	logic serial0_receive_in, ext_irq_zero_in, ext_irq_one_in, timer_zero_ext_input;
	logic [7:0] p0_wr_data, p2_wr_data, p3_wr_data, p4_wr_data, bus_wr_data, bus_rd_data;
	logic [7:0] p3_alt_en, p4_alt_en, p0_level, p2_level, p3_level, p4_level, p0_ext_en, p0_ext;
	logic [7:0] low_addr_data_lines_i, low_addr_data_lines_o, low_addr_data_lines_oe, p3_ext_en;
	logic [7:0] high_address_lines_i, high_address_lines_o, high_address_lines_oe, p3_ext;
	logic [7:0] high_address_lines_wpu, p3_pin_i, p3_pin_o, p3_pin_oe, p3_pin_wpu;
	logic [7:0] p4_pin_i, p4_pin_o, p4_pin_oe, p4_pin_wpu, p2_ext_en, p2_ext;
	logic [15:0] bus_addr;
	logic [5:0] compare_setreset_out;
	logic [1:0] compare_toggle_out;
	int fails, cmp_count, cycles;

	pfm_port_mux #(.W(8)) i_pfm_port_mux (.sys_clk, .rst_b, .p0_wr_en, .p0_wr_data, .p2_wr_en,
		.p2_wr_data, .p3_wr_en, .p3_wr_data, .p4_wr_en, .p4_wr_data, .bus_active, .bus_ale,
		.bus_addr, .bus_data_oe, .bus_wr_data, .bus_rd_data, .ale_out, .p3_alt_en, .p4_alt_en,
		.serial0_transmit_out, .wr_strobe_b, .rd_strobe_b, .compare_setreset_out,
		.compare_toggle_out, .serial0_receive_in, .ext_irq_zero_in, .ext_irq_one_in,
		.timer_zero_ext_input, .p0_level, .p2_level, .p3_level, .p4_level,
		.low_addr_data_lines_i, .low_addr_data_lines_o, .low_addr_data_lines_oe,
		.high_address_lines_i, .high_address_lines_o, .high_address_lines_oe,
		.high_address_lines_wpu, .p3_pin_i, .p3_pin_o, .p3_pin_oe, .p3_pin_wpu, .p4_pin_i,
		.p4_pin_o, .p4_pin_oe, .p4_pin_wpu);
	// board: pullups on the low port, outside sources on low, high and third ports
	pfm_board_pins i_pfm_board_pins_p0 (.o(low_addr_data_lines_o), .oe(low_addr_data_lines_oe),
		.wpu(8'hFF), .ext_en(p0_ext_en), .ext(p0_ext), .lvl(low_addr_data_lines_i));
	pfm_board_pins i_pfm_board_pins_p2 (.o(high_address_lines_o), .oe(high_address_lines_oe),
		.wpu(high_address_lines_wpu), .ext_en(p2_ext_en), .ext(p2_ext), .lvl(high_address_lines_i));
	pfm_board_pins i_pfm_board_pins_p3 (.o(p3_pin_o), .oe(p3_pin_oe), .wpu(p3_pin_wpu),
		.ext_en(p3_ext_en), .ext(p3_ext), .lvl(p3_pin_i));
	pfm_board_pins i_pfm_board_pins_p4 (.o(p4_pin_o), .oe(p4_pin_oe), .wpu(p4_pin_wpu),
		.ext_en(8'h00), .ext(8'h00), .lvl(p4_pin_i));

	// shared helpers
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// reset state, then low port as open-drain I/O
	task automatic t_reset_io();
		step(1);
		chk(low_addr_data_lines_oe, 8'h00);
		chk(high_address_lines_wpu, 8'hFF);
		chk(high_address_lines_oe, 8'h00);
		step(1);
		rst_b = 1'b1;
		p0_wr_en = 1'b1;
		p0_wr_data = 8'h5A;
		step(1);
		p0_wr_en = 1'b0;
		step(1);
		chk(low_addr_data_lines_oe, 8'hA5);
		chk(low_addr_data_lines_o, 8'h00);
		step(1);
		chk(p0_level, 8'h5A);
	endtask
	// external access: address, write data, then read data
	task automatic t_bus();
		{bus_active, bus_ale, bus_addr} = {2'b11, 16'h1234};
		step(1);
		chk(low_addr_data_lines_o, 8'h34);
		chk({7'h00, ale_out}, 8'h01);
		chk(high_address_lines_o, 8'h12);
		chk(high_address_lines_oe, 8'hFF);
		{bus_ale, bus_data_oe, bus_wr_data} = {2'b01, 8'hA5};
		step(1);
		chk(low_addr_data_lines_o, 8'hA5);
		chk({7'h00, ale_out}, 8'h00);
		chk(low_addr_data_lines_oe, 8'hFF);
		{bus_data_oe, p0_ext_en, p0_ext} = {1'b0, 16'hFFC3};
		step(1);
		chk(low_addr_data_lines_oe, 8'h00);
		step(1);
		chk(bus_rd_data, 8'hC3);
		{bus_active, p0_ext_en} = 9'h000;
		step(4);
	endtask
	// quasi pin: strong low, then short strong high pulse
	task automatic t_qb(input logic [7:0] v);
		{p2_wr_en, p2_wr_data} = {1'b1, v};
		step(1);
		p2_wr_en = 1'b0;
		step(1);
		chk(high_address_lines_o, v);
		chk(high_address_lines_oe, 8'hFF);
		step(2);
		chk(high_address_lines_oe, v == 8'h00 ? 8'hFF : 8'h00);
		// outside source shows only where the pin is not driven strongly
		{p2_ext_en, p2_ext} = 16'hFF3C;
		step(1);
		chk(p2_level, v & 8'h3C);
		p2_ext_en = 8'h00;
	endtask
	// alternate functions, then plain I/O and input pins
	task automatic t_alt();
		{p3_alt_en, p4_alt_en, serial0_transmit_out, wr_strobe_b} = 18'h3FFFC;
		{compare_toggle_out, compare_setreset_out} = 8'h6A;
		step(2);
		chk(p3_pin_i, 8'hBD);
		chk(p4_pin_i, 8'h6A);
		{serial0_transmit_out, wr_strobe_b, rd_strobe_b} = 3'b110;
		{compare_toggle_out, compare_setreset_out} = 8'h95;
		step(2);
		chk(p3_pin_i, 8'h7F);
		chk(p4_pin_i, 8'h95);
		{p3_alt_en, p4_alt_en, p3_wr_en, p4_wr_en} = 18'h00003;
		{p3_wr_data, p4_wr_data} = 16'h0FF0;
		step(1);
		{p3_wr_en, p4_wr_en} = 2'b00;
		step(1);
		chk(p3_pin_i, 8'h0F);
		chk(p4_pin_i, 8'hF0);
		{p3_ext_en, p3_ext} = 16'h1D00;
		step(2);
		chk({4'h0, timer_zero_ext_input, ext_irq_one_in, ext_irq_zero_in, serial0_receive_in},
			8'h00);
		chk(p3_level, 8'h02);
		chk(p4_level, 8'hF0);
	endtask

	// clock and cycle ceiling
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		{rst_b, p0_wr_en, p2_wr_en, p3_wr_en, p4_wr_en, bus_active, bus_ale, bus_data_oe} = 8'h80;
		{p2_ext_en, p2_ext} = 16'h0;
		{p0_wr_data, p2_wr_data, p3_wr_data, p4_wr_data, bus_wr_data, bus_addr} = 56'h0;
		{p3_alt_en, p4_alt_en, p0_ext_en, p0_ext, p3_ext_en, p3_ext} = 48'h0;
		{serial0_transmit_out, wr_strobe_b, rd_strobe_b} = 3'b111;
		{compare_toggle_out, compare_setreset_out} = 8'h00;
		// clean falling edge so the asynchronous reset is seen
		#1 rst_b = 1'b0;
		t_reset_io();
		t_bus();
		t_qb(8'h00);
		t_qb(8'hFF);
		t_alt();
		print_verdict();
	end
endmodule
